// file: src/ivc_pkg.sv
// Purpose: constants and types for the interrupt vector and control block
// Assumes: 20-bit byte address space, byte-wide vector fetch port
// Notes: fixed vectors sit at the top of memory
package ivc_pkg;
    // ********************************
    // vector map
    // ********************************
    localparam int IVC_AW = 20;
    localparam logic [19:0] IVC_VEC_UNDEF = 20'hfffdc;
    localparam logic [19:0] IVC_VEC_OVF = 20'hfffe0;
    localparam logic [19:0] IVC_VEC_BRK = 20'hfffe4;
    localparam logic [19:0] IVC_VEC_MATCH = 20'hfffe8;
    localparam logic [19:0] IVC_VEC_STEP = 20'hfffec;
    localparam logic [19:0] IVC_VEC_OSCWDT = 20'hffff0;
    localparam logic [19:0] IVC_VEC_DEBUG = 20'hffff4;
    localparam logic [19:0] IVC_VEC_NMI = 20'hffff8;
    localparam logic [19:0] IVC_VEC_RESET = 20'hffffc;
    localparam logic [7:0] IVC_BRK_REDIRECT = 8'hff;
    localparam logic [1:0] IVC_LAST_BYTE = 2'h3;
    // ********************************
    // slots of the relocatable table
    // ********************************
    localparam int IVC_SLOT_LAST = 31;
    localparam int IVC_SLOT_INT3 = 4;
    localparam int IVC_SLOT_B4 = 6;
    localparam int IVC_SLOT_B3 = 7;
    localparam int IVC_SLOT_CAN1RX = 8;
    localparam int IVC_SLOT_SER3 = 9;
    localparam int IVC_SLOT_U2COL = 10;
    localparam int IVC_SLOT_ADC = 14;
    localparam int IVC_SLOT_U2TX = 15;
    localparam int IVC_SLOT_U0TX = 17;
    localparam int IVC_SLOT_U1TX = 19;
    localparam int IVC_SLOT_INT0 = 29;
    // ********************************
    // source select bit positions
    // ********************************
    localparam int IVC_S0_B4 = 7;
    localparam int IVC_S0_B3 = 6;
    localparam int IVC_S0_SER3 = 0;
    localparam int IVC_S0_ADC = 1;
    localparam int IVC_S1_SLOT8 = 7;
    localparam int IVC_S1_SLOT9 = 6;
    // ********************************
    // types
    // ********************************
    typedef enum logic [3:0] {
        IVC_K_UNDEF = 4'h0, IVC_K_OVF = 4'h1, IVC_K_BRK = 4'h2, IVC_K_MATCH = 4'h3,
        IVC_K_STEP = 4'h4, IVC_K_OSCWDT = 4'h5, IVC_K_DEBUG = 4'h6, IVC_K_NMI = 4'h7,
        IVC_K_RESET = 4'h8, IVC_K_SOFT = 4'h9
    } ivc_kind_e;
    typedef enum logic [2:0] {
        IVC_S_IDLE = 3'b000, IVC_S_WAIT = 3'b001, IVC_S_ISSUE = 3'b010,
        IVC_S_LAT = 3'b011, IVC_S_CAPT = 3'b100
    } ivc_state_e;
endpackage

// file: src/ivc_top.sv
// Purpose: request flags, source routing, acceptance check and vector fetch
// Assumes: MEM_DATA valid in the cycle after MEM_RD is high
// Notes: all state freezes while CLK_EN is low
`timescale 1ns/10ps
`default_nettype none
module ivc_top
    import ivc_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic [19:0] VECTOR_TABLE_BASE,
    input wire logic GLOBAL_ENABLE,
    input wire logic [2:0] PROCESSOR_PRIORITY_LEVEL,
    input wire logic [95:0] PRIORITY_LEVEL_FIELD,
    input wire logic [7:0] SOURCE_SELECT_REG_0,
    input wire logic [7:0] SOURCE_SELECT_REG_1,
    input wire logic [5:0] EDGE_POLARITY_BIT,
    input wire logic [31:0] PERIPH_REQ,
    input wire logic SERIAL3_REQ,
    input wire logic KEY_REQ,
    input wire logic [2:0] I2C_MODE,
    input wire logic [2:0] I2C_ACK_EVT,
    input wire logic [2:0] I2C_NACK_EVT,
    input wire logic [2:0] I2C_STARTSTOP_EVT,
    input wire logic [2:0] BUS_COLLISION_EVT,
    input wire logic [5:0] EXT_PIN,
    input wire logic NMI_PIN_N,
    input wire logic FLAG_WRITE,
    input wire logic [4:0] FLAG_WRITE_SLOT,
    input wire logic FLAG_WRITE_VALUE,
    input wire logic [19:0] EXEC_ADDR,
    input wire logic EXEC_VALID,
    input wire logic [19:0] MATCH_ADDR_0,
    input wire logic [19:0] MATCH_ADDR_1,
    input wire logic [19:0] MATCH_ADDR_2,
    input wire logic [19:0] MATCH_ADDR_3,
    input wire logic [3:0] MATCH_ENABLE,
    input wire logic VEC_REQ,
    input wire logic [3:0] VEC_KIND,
    input wire logic [5:0] VEC_NUM,
    input wire logic VEC_HW,
    input wire logic [7:0] MEM_DATA,
    output logic [31:0] REQUEST_PENDING_FLAG,
    output logic REQUEST_VALID,
    output logic [5:0] REQUEST_NUMBER,
    output logic [2:0] REQUEST_LEVEL,
    output logic ADDR_MATCH_REQ,
    output logic NMI_REQ,
    output logic VEC_BUSY,
    output logic MEM_RD,
    output logic [19:0] MEM_ADDR,
    output logic [19:0] TARGET_ADDR,
    output logic TARGET_VALID
);
    // ********************************
    // event routing and pin edges
    // ********************************
    logic [5:0] pin_prev;
    logic nmi_prev;
    logic [5:0] pin_evt;
    logic [2:0] col_evt;
    logic [31:0] ev;
    logic nmi_evt;
    logic match_hit;

    always_comb begin
        for (int p = 0; p < 6; p++) begin
            if (SOURCE_SELECT_REG_1[p]) begin
                pin_evt[p] = EXT_PIN[p] ^ pin_prev[p];
            end else if (EDGE_POLARITY_BIT[p]) begin
                pin_evt[p] = EXT_PIN[p] & ~pin_prev[p];
            end else begin
                pin_evt[p] = ~EXT_PIN[p] & pin_prev[p];
            end
        end
        col_evt = (I2C_MODE & I2C_STARTSTOP_EVT) | (~I2C_MODE & BUS_COLLISION_EVT);
        nmi_evt = ~NMI_PIN_N & nmi_prev;
        ev = PERIPH_REQ;
        ev[0] = 1'b0;
        ev[IVC_SLOT_INT3] = pin_evt[3];
        ev[IVC_SLOT_B4] = SOURCE_SELECT_REG_0[IVC_S0_B4] ? col_evt[1] : PERIPH_REQ[IVC_SLOT_B4];
        ev[IVC_SLOT_B3] = SOURCE_SELECT_REG_0[IVC_S0_B3] ? col_evt[0] : PERIPH_REQ[IVC_SLOT_B3];
        ev[IVC_SLOT_CAN1RX] = SOURCE_SELECT_REG_1[IVC_S1_SLOT8] ? pin_evt[5] : PERIPH_REQ[IVC_SLOT_CAN1RX];
        if (SOURCE_SELECT_REG_1[IVC_S1_SLOT9]) begin
            ev[IVC_SLOT_SER3] = pin_evt[4];
        end else begin
            ev[IVC_SLOT_SER3] = SOURCE_SELECT_REG_0[IVC_S0_SER3] ? SERIAL3_REQ : PERIPH_REQ[IVC_SLOT_SER3];
        end
        ev[IVC_SLOT_U2COL] = col_evt[2];
        ev[IVC_SLOT_ADC] = SOURCE_SELECT_REG_0[IVC_S0_ADC] ? KEY_REQ : PERIPH_REQ[IVC_SLOT_ADC];
        ev[IVC_SLOT_U2TX] = I2C_MODE[2] ? I2C_NACK_EVT[2] : PERIPH_REQ[IVC_SLOT_U2TX];
        ev[IVC_SLOT_U2TX + 1] = I2C_MODE[2] ? I2C_ACK_EVT[2] : PERIPH_REQ[IVC_SLOT_U2TX + 1];
        ev[IVC_SLOT_U0TX] = I2C_MODE[0] ? I2C_NACK_EVT[0] : PERIPH_REQ[IVC_SLOT_U0TX];
        ev[IVC_SLOT_U0TX + 1] = I2C_MODE[0] ? I2C_ACK_EVT[0] : PERIPH_REQ[IVC_SLOT_U0TX + 1];
        ev[IVC_SLOT_U1TX] = I2C_MODE[1] ? I2C_NACK_EVT[1] : PERIPH_REQ[IVC_SLOT_U1TX];
        ev[IVC_SLOT_U1TX + 1] = I2C_MODE[1] ? I2C_ACK_EVT[1] : PERIPH_REQ[IVC_SLOT_U1TX + 1];
        ev[IVC_SLOT_INT0 +: 3] = pin_evt[2:0];
        match_hit = EXEC_VALID & ((MATCH_ENABLE[0] & (EXEC_ADDR == MATCH_ADDR_0)) |
            (MATCH_ENABLE[1] & (EXEC_ADDR == MATCH_ADDR_1)) |
            (MATCH_ENABLE[2] & (EXEC_ADDR == MATCH_ADDR_2)) |
            (MATCH_ENABLE[3] & (EXEC_ADDR == MATCH_ADDR_3)));
    end

    // ********************************
    // request flags and acceptance
    // ********************************
    logic [31:0] pend;
    logic [31:0] next_pend;
    logic next_req_valid;
    logic [5:0] next_req_num;
    logic [2:0] next_req_lvl;
    logic next_match_req;
    logic next_nmi_req;
    logic take;
    logic [2:0] lvl;
    logic [2:0] best;
    ivc_state_e state;

    always_comb begin
        take = VEC_REQ & (state == IVC_S_IDLE);
        next_pend = pend;
        for (int i = 1; i <= IVC_SLOT_LAST; i++) begin
            if (FLAG_WRITE && !FLAG_WRITE_VALUE && (FLAG_WRITE_SLOT == 5'(i))) begin
                next_pend[i] = 1'b0;
            end
            if (take && VEC_HW && (VEC_KIND == IVC_K_SOFT) && (VEC_NUM == 6'(i))) begin
                next_pend[i] = 1'b0;
            end
            if (ev[i]) begin
                next_pend[i] = 1'b1;
            end
        end
        lvl = 3'h0;
        best = PROCESSOR_PRIORITY_LEVEL;
        next_req_valid = 1'b0;
        next_req_num = 6'h00;
        for (int i = 1; i <= IVC_SLOT_LAST; i++) begin
            lvl = PRIORITY_LEVEL_FIELD[3 * i +: 3];
            if (pend[i] && (lvl > best)) begin
                best = lvl;
                next_req_valid = GLOBAL_ENABLE;
                next_req_num = 6'(i);
            end
        end
        next_req_lvl = best;
        next_match_req = match_hit | (ADDR_MATCH_REQ & ~(take & (VEC_KIND == IVC_K_MATCH)));
        next_nmi_req = nmi_evt | (NMI_REQ & ~(take & (VEC_KIND == IVC_K_NMI)));
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pend <= 32'h0000_0000;
            pin_prev <= 6'h3f;
            nmi_prev <= 1'b1;
            REQUEST_VALID <= 1'b0;
            REQUEST_NUMBER <= 6'h00;
            REQUEST_LEVEL <= 3'h0;
            ADDR_MATCH_REQ <= 1'b0;
            NMI_REQ <= 1'b0;
        end else if (CLK_EN) begin
            pend <= next_pend;
            pin_prev <= EXT_PIN;
            nmi_prev <= NMI_PIN_N;
            REQUEST_VALID <= next_req_valid;
            REQUEST_NUMBER <= next_req_num;
            REQUEST_LEVEL <= next_req_lvl;
            ADDR_MATCH_REQ <= next_match_req;
            NMI_REQ <= next_nmi_req;
        end
    end

    assign REQUEST_PENDING_FLAG = pend;

    // ********************************
    // vector fetch
    // ********************************
    ivc_state_e next_state;
    ivc_kind_e kind;
    ivc_kind_e next_kind;
    logic [19:0] addr;
    logic [19:0] next_addr;
    logic [1:0] idx;
    logic [1:0] next_idx;
    logic [31:0] bytes;
    logic [31:0] next_bytes;
    logic next_mem_rd;
    logic [19:0] next_mem_addr;
    logic [19:0] next_target;
    logic next_target_valid;
    logic [19:0] start;

    always_comb begin
        case (ivc_kind_e'(VEC_KIND))
            IVC_K_UNDEF: start = IVC_VEC_UNDEF;
            IVC_K_OVF: start = IVC_VEC_OVF;
            IVC_K_BRK: start = IVC_VEC_BRK;
            IVC_K_MATCH: start = IVC_VEC_MATCH;
            IVC_K_STEP: start = IVC_VEC_STEP;
            IVC_K_OSCWDT: start = IVC_VEC_OSCWDT;
            IVC_K_DEBUG: start = IVC_VEC_DEBUG;
            IVC_K_NMI: start = IVC_VEC_NMI;
            IVC_K_RESET: start = IVC_VEC_RESET;
            default: start = VECTOR_TABLE_BASE + {12'h000, VEC_NUM, 2'b00};
        endcase
        next_state = state;
        next_kind = kind;
        next_addr = addr;
        next_idx = idx;
        next_bytes = bytes;
        next_mem_rd = 1'b0;
        next_mem_addr = MEM_ADDR;
        next_target = TARGET_ADDR;
        next_target_valid = 1'b0;
        case (state)
            IVC_S_IDLE: begin
                if (VEC_REQ) begin
                    next_kind = ivc_kind_e'(VEC_KIND);
                    next_addr = start;
                    next_idx = 2'h0;
                    next_state = start[0] ? IVC_S_WAIT : IVC_S_ISSUE;
                end
            end
            IVC_S_WAIT: next_state = IVC_S_ISSUE;
            IVC_S_ISSUE: begin
                next_mem_rd = 1'b1;
                next_mem_addr = addr + {18'h0, idx};
                next_state = IVC_S_LAT;
            end
            IVC_S_LAT: next_state = IVC_S_CAPT;
            IVC_S_CAPT: begin
                next_bytes[8 * idx +: 8] = MEM_DATA;
                if (idx != IVC_LAST_BYTE) begin
                    next_idx = idx + 2'h1;
                    next_state = addr[0] ? IVC_S_WAIT : IVC_S_ISSUE;
                end else if ((kind == IVC_K_BRK) && (MEM_DATA == IVC_BRK_REDIRECT)) begin
                    next_kind = IVC_K_SOFT;
                    next_addr = VECTOR_TABLE_BASE;
                    next_idx = 2'h0;
                    next_state = VECTOR_TABLE_BASE[0] ? IVC_S_WAIT : IVC_S_ISSUE;
                end else begin
                    next_target = {bytes[19:0]};
                    next_target_valid = 1'b1;
                    next_state = IVC_S_IDLE;
                end
            end
            default: next_state = IVC_S_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state <= IVC_S_IDLE;
            kind <= IVC_K_RESET;
            addr <= 20'h00000;
            idx <= 2'h0;
            bytes <= 32'h0000_0000;
            VEC_BUSY <= 1'b0;
            MEM_RD <= 1'b0;
            MEM_ADDR <= 20'h00000;
            TARGET_ADDR <= 20'h00000;
            TARGET_VALID <= 1'b0;
        end else if (CLK_EN) begin
            state <= next_state;
            kind <= next_kind;
            addr <= next_addr;
            idx <= next_idx;
            bytes <= next_bytes;
            VEC_BUSY <= (next_state != IVC_S_IDLE);
            MEM_RD <= next_mem_rd;
            MEM_ADDR <= next_mem_addr;
            TARGET_ADDR <= next_target;
            TARGET_VALID <= next_target_valid;
        end
    end

    // ********************************
    // checks
    // ********************************
    AST_PEND_SET: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        CLK_EN |=> ((pend & $past(ev)) == $past(ev)))
        else $error("event did not set its flag");
    AST_SW_CLEAR: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        CLK_EN && FLAG_WRITE && !FLAG_WRITE_VALUE && (ev == 32'h0) |=> !pend[$past(FLAG_WRITE_SLOT)])
        else $error("write of 0 did not clear flag");
    AST_NO_SW_SET: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        CLK_EN && FLAG_WRITE && FLAG_WRITE_VALUE && (ev == 32'h0) && !pend[FLAG_WRITE_SLOT]
        |=> !pend[$past(FLAG_WRITE_SLOT)])
        else $error("write of 1 set a flag");
    AST_ACCEPT: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        $past(CLK_EN) && REQUEST_VALID |-> $past(GLOBAL_ENABLE)
        && ((($past(pend) >> REQUEST_NUMBER) & 32'h0000_0001) != 32'h0000_0000)
        && (REQUEST_LEVEL > $past(PROCESSOR_PRIORITY_LEVEL)))
        else $error("request offered without acceptance conditions");
    AST_LEVEL0: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        REQUEST_VALID |-> (REQUEST_LEVEL != 3'h0))
        else $error("level 0 request offered");
    AST_FIXED: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        MEM_RD && (kind != IVC_K_SOFT) |-> (MEM_ADDR >= IVC_VEC_UNDEF))
        else $error("fixed vector read below table");
    AST_BRK: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        CLK_EN && (state == IVC_S_CAPT) && (kind == IVC_K_BRK) && (idx == IVC_LAST_BYTE)
        && (MEM_DATA == IVC_BRK_REDIRECT) |=> (kind == IVC_K_SOFT) && !TARGET_VALID)
        else $error("break redirect not taken");
    AST_FOUR: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        $past(CLK_EN) && TARGET_VALID |-> ($past(state) == IVC_S_CAPT) && ($past(idx) == IVC_LAST_BYTE))
        else $error("target before fourth byte");
    AST_ODD: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        CLK_EN && (state == IVC_S_CAPT) && (idx != IVC_LAST_BYTE) && addr[0] |=> (state == IVC_S_WAIT))
        else $error("odd vector missed wait");
    AST_MATCH: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        CLK_EN && match_hit |=> ADDR_MATCH_REQ)
        else $error("address match not raised");
    COV_REDIRECT: cover property (@(posedge CLOCK) disable iff (SYS_RST)
        (state == IVC_S_CAPT) && (kind == IVC_K_BRK) && (MEM_DATA == IVC_BRK_REDIRECT) && (idx == IVC_LAST_BYTE));
    COV_ODD: cover property (@(posedge CLOCK) disable iff (SYS_RST) TARGET_VALID && addr[0]);
    COV_REQ: cover property (@(posedge CLOCK) disable iff (SYS_RST) REQUEST_VALID && (REQUEST_LEVEL == 3'h7));
endmodule
`default_nettype wire

// file: testbench/ivc_mem_model.sv
// Purpose: byte memory behind the vector fetch port
// Assumes: data is due in the cycle after a read strobe
// Notes: an idle data line toggles every cycle
`timescale 1ns/10ps
`default_nettype none
module ivc_mem_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic mem_rd,
    input wire logic [19:0] mem_addr,
    input wire logic redirect,
    output logic [7:0] mem_data
);
    // ********************************
    // byte store
    // ********************************
    function automatic logic [7:0] byte_at(input logic [19:0] a);
        if (redirect && a == 20'hfffe7) begin
            return 8'hff;
        end
        return a[7:0] ^ 8'h3c;
    endfunction
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            mem_data <= 8'h00;
        end else if (mem_rd) begin
            mem_data <= byte_at(mem_addr);
        end else begin
            mem_data <= ~mem_data;
        end
    end
endmodule
`default_nettype wire

// file: testbench/interrupt_vector_and_control_tb_top.sv
// Purpose: self-checking bench for the vector and request block
// Assumes: memory model answers every read strobe
// Notes: vector bytes are address xor 3c
`timescale 1ns/10ps
`default_nettype none
module interrupt_vector_and_control_tb_top;
    import ivc_pkg::*;
    logic clock, sys_rst, clk_en, ge, nmi_n, fw, fwv, exec_valid, vec_req, vec_hw, ser3, key, redirect;
    logic [19:0] base, exec_addr, ma0, ma1, ma2, ma3, mem_addr, tgt;
    logic [2:0] processor_priority_level, i2c_mode, ack, nack, ss, col, req_l;
    logic [95:0] plf;
    logic [7:0] sel0, sel1, mem_data;
    logic [5:0] edge_polarity_bit, ext, vec_num, req_n;
    logic [31:0] preq, flag;
    logic [4:0] fws;
    logic [3:0] men, vec_kind;
    logic req_v, am_req, nmi_req, busy, mem_rd, tv;
    int err_count, checks;
    ivc_top dut_u (.CLOCK(clock), .SYS_RST(sys_rst), .CLK_EN(clk_en), .VECTOR_TABLE_BASE(base),
        .GLOBAL_ENABLE(ge), .PROCESSOR_PRIORITY_LEVEL(processor_priority_level), .PRIORITY_LEVEL_FIELD(plf),
        .SOURCE_SELECT_REG_0(sel0), .SOURCE_SELECT_REG_1(sel1), .EDGE_POLARITY_BIT(edge_polarity_bit),
        .PERIPH_REQ(preq), .SERIAL3_REQ(ser3), .KEY_REQ(key), .I2C_MODE(i2c_mode), .I2C_ACK_EVT(ack),
        .I2C_NACK_EVT(nack), .I2C_STARTSTOP_EVT(ss), .BUS_COLLISION_EVT(col), .EXT_PIN(ext),
        .NMI_PIN_N(nmi_n), .FLAG_WRITE(fw), .FLAG_WRITE_SLOT(fws), .FLAG_WRITE_VALUE(fwv),
        .EXEC_ADDR(exec_addr), .EXEC_VALID(exec_valid), .MATCH_ADDR_0(ma0), .MATCH_ADDR_1(ma1),
        .MATCH_ADDR_2(ma2), .MATCH_ADDR_3(ma3), .MATCH_ENABLE(men), .VEC_REQ(vec_req),
        .VEC_KIND(vec_kind), .VEC_NUM(vec_num), .VEC_HW(vec_hw), .MEM_DATA(mem_data),
        .REQUEST_PENDING_FLAG(flag), .REQUEST_VALID(req_v), .REQUEST_NUMBER(req_n),
        .REQUEST_LEVEL(req_l), .ADDR_MATCH_REQ(am_req), .NMI_REQ(nmi_req), .VEC_BUSY(busy),
        .MEM_RD(mem_rd), .MEM_ADDR(mem_addr), .TARGET_ADDR(tgt), .TARGET_VALID(tv));
    ivc_mem_model mem_u (.clock(clock), .sys_rst(sys_rst), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .redirect(redirect), .mem_data(mem_data));
    // ********************************
    // helpers
    // ********************************
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    function automatic logic [19:0] exp_tgt(input logic [19:0] a);
        logic [19:0] a1;
        logic [19:0] a2;
        a1 = a + 20'h1;
        a2 = a + 20'h2;
        return {a2[3:0] ^ 4'hc, a1[7:0] ^ 8'h3c, a[7:0] ^ 8'h3c};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        $display("checks=%0d err_count=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic fetch(input logic [3:0] k, input logic [5:0] n, input logic [19:0] a, input int cyc,
        input logic hw);
        int i;
        int got;
        got = 0;
        @(posedge clock);
        vec_req <= 1'b1;
        vec_kind <= k;
        vec_num <= n;
        vec_hw <= hw;
        @(posedge clock);
        vec_req <= 1'b0;
        for (i = 1; i <= 40 && got == 0; i++) begin
            @(posedge clock);
            #1;
            if (i == 1) chk(busy, 1'b1);
            if (tv === 1'b1) got = i + 1;
        end
        if (got == 0) begin
            err_count++;
            end_sim();
        end else begin
            chk(got, cyc);
            chk(tgt, exp_tgt(a));
            chk(busy, 1'b0);
        end
    endtask
    task automatic wflag(input logic [4:0] s, input logic v);
        @(posedge clock);
        fw <= 1'b1;
        fws <= s;
        fwv <= v;
        @(posedge clock);
        fw <= 1'b0;
        #1;
    endtask
    task automatic pulse_req(input int n);
        @(posedge clock);
        preq[n] <= 1'b1;
        @(posedge clock);
        preq <= 32'h0;
        #1;
    endtask
    // ********************************
    // scenarios
    // ********************************
    task automatic t_fixed;
        for (int k = 0; k < 9; k++) fetch(k[3:0], 6'h0, 20'hfffdc + 20'(4 * k), 13, 1'b0);
    endtask
    task automatic t_reloc;
        @(posedge clock);
        base <= 20'h04000;
        fetch(4'h9, 6'd0, 20'h04000, 13, 1'b0);
        fetch(4'h9, 6'd63, 20'h040fc, 13, 1'b0);
        @(posedge clock);
        base <= 20'h04001;
        fetch(4'h9, 6'd5, 20'h04015, 17, 1'b0);
        @(posedge clock);
        base <= 20'h04000;
        redirect <= 1'b1;
        fetch(4'h2, 6'd0, 20'h04000, 25, 1'b0);
        redirect <= 1'b0;
    endtask
    task automatic t_flag;
        @(posedge clock);
        plf[65:63] <= 3'h3;
        processor_priority_level <= 3'h2;
        ge <= 1'b1;
        pulse_req(21);
        chk(flag[21], 1'b1);
        @(posedge clock);
        #1;
        chk({req_v, req_n, req_l}, {1'b1, 6'd21, 3'h3});
        processor_priority_level <= 3'h3;
        repeat (2) @(posedge clock);
        #1;
        chk(req_v, 1'b0);
        processor_priority_level <= 3'h2;
        ge <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk(req_v, 1'b0);
        ge <= 1'b1;
        plf[65:63] <= 3'h0;
        repeat (2) @(posedge clock);
        #1;
        chk(req_v, 1'b0);
        wflag(5'd22, 1'b1);
        chk(flag[22], 1'b0);
        wflag(5'd21, 1'b0);
        chk(flag[21], 1'b0);
        pulse_req(21);
        fetch(4'h9, 6'd21, 20'h04054, 13, 1'b1);
        chk(flag[21], 1'b0);
    endtask
    task automatic t_hold;
        @(posedge clock);
        clk_en <= 1'b0;
        pulse_req(22);
        chk(flag[22], 1'b0);
        @(posedge clock);
        clk_en <= 1'b1;
        pulse_req(22);
        chk(flag[22], 1'b1);
    endtask
    task automatic t_pins;
        @(posedge clock);
        sel1 <= 8'h01;
        edge_polarity_bit <= 6'h02;
        ext <= 6'h38;
        @(posedge clock);
        #1;
        chk({flag[31], flag[30], flag[29]}, 3'b101);
        wflag(5'd29, 1'b0);
        wflag(5'd31, 1'b0);
        ext <= 6'h3f;
        @(posedge clock);
        #1;
        chk({flag[31], flag[30], flag[29]}, 3'b011);
        sel1 <= 8'h00;
        edge_polarity_bit <= 6'h00;
    endtask
    task automatic t_shared;
        @(posedge clock);
        sel0 <= 8'h01;
        ser3 <= 1'b1;
        @(posedge clock);
        ser3 <= 1'b0;
        i2c_mode <= 3'b100;
        nack <= 3'b100;
        @(posedge clock);
        nack <= 3'b000;
        ack <= 3'b100;
        @(posedge clock);
        ack <= 3'b000;
        ss <= 3'b100;
        @(posedge clock);
        ss <= 3'b000;
        #1;
        chk({flag[9], flag[15], flag[16], flag[10]}, 4'hf);
    endtask
    task automatic t_special;
        @(posedge clock);
        ma2 <= 20'h12344;
        men <= 4'b0010;
        exec_addr <= 20'h12344;
        exec_valid <= 1'b1;
        @(posedge clock);
        men <= 4'b0100;
        #1;
        chk(am_req, 1'b0);
        @(posedge clock);
        exec_valid <= 1'b0;
        #1;
        chk(am_req, 1'b1);
        fetch(4'h3, 6'd0, 20'hfffe8, 13, 1'b0);
        chk(am_req, 1'b0);
        @(posedge clock);
        nmi_n <= 1'b0;
        for (int i = 0; i < 4 && nmi_req !== 1'b1; i++) begin
            @(posedge clock);
            #1;
        end
        chk(nmi_req, 1'b1);
        nmi_n <= 1'b1;
        fetch(4'h7, 6'd0, 20'hffff8, 13, 1'b0);
        chk(nmi_req, 1'b0);
    endtask
    // ********************************
    // main sequence
    // ********************************
    initial begin
        {sys_rst, nmi_n, clk_en, ext} = {1'b1, 1'b1, 1'b1, 6'h3f};
        {ge, fw, fwv, exec_valid, vec_req, vec_hw, ser3, key, redirect} = '0;
        {base, exec_addr, ma0, ma1, ma2, ma3, processor_priority_level, i2c_mode, ack, nack, ss, col} = '0;
        {plf, sel0, sel1, edge_polarity_bit, vec_num, preq, fws, men, vec_kind} = '0;
        {err_count, checks} = '0;
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        #1;
        chk(flag, 32'h0);
        t_fixed();
        t_reloc();
        t_flag();
        t_hold();
        t_pins();
        t_shared();
        t_special();
        end_sim();
    end
endmodule
`default_nettype wire
